// file: rtl/cfg_mem.sv
// single-port byte memory with registered read data
// assumes one clock; read during write returns the old word
`timescale 1ns/10ps
`default_nettype none
module cfg_mem #(
  parameter int AW        = 9,
  parameter int DW        = 8,
  parameter bit INIT_ZERO = 1'b0
) (
  input  wire logic          clk,    // system clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] addr,   // word address
  input  wire logic [DW-1:0] wdata,  // write data
  output var  logic [DW-1:0] rdata_q // read data, one cycle after addr
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // blank store reads as factory zeros rather than unknowns
  initial begin
    if (INIT_ZERO) begin
      for (int i = 0; i < (1 << AW); i++) begin
        mem[i] = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule // cfg_mem
`default_nettype wire

// file: rtl/clkcfg_pkg.sv
// constants and carrier types for the clock generator configuration loader
// assumes one 100 MHz clock and a byte-wide register space behind I2C or SPI
package clkcfg_pkg;

  localparam int          ADDR_W        = 9;                // register index width
  localparam int          NREG          = 512;              // bytes in the register space
  localparam int          STO_AW        = ADDR_W + 2;       // two bank bits above the index
  localparam int          NUM_BYTES     = 6;                // numerator bytes
  localparam int          DEN_BYTES     = 4;                // denominator bytes
  localparam int          MAX_BURNS     = 2;                // store may be written twice

  // register locations
  localparam logic [8:0]  AMP6_ADDR      = 9'h128;
  localparam int          OUT6_LSB       = 4;
  localparam int          OUT6_W         = 3;
  localparam logic [8:0]  SPI_CFG_ADDR   = 9'h02b;
  localparam int          SPI_3W_BIT     = 3;
  localparam logic [8:0]  STO_STAT_ADDR  = 9'h0e2;
  localparam logic [8:0]  STO_CMD_ADDR   = 9'h0e3;
  localparam logic [7:0]  STO_CMD_GO     = 8'h01;
  localparam logic [8:0]  NUM_BASE       = 9'h1a0;
  localparam logic [8:0]  DEN_BASE       = 9'h1a6;
  localparam logic [8:0]  UPDATE_ADDR    = 9'h1aa;
  localparam int          UPDATE_BIT     = 0;

  // store layout: bank 0 factory image, banks 1 and 2 user burns, bank 3 word 0 = burn count
  localparam logic [1:0]  CNT_BANK       = 2'h3;

  // spi command byte
  localparam logic [7:0]  SPI_CMD_RD     = 8'h80;

  // serial byte positions within a transfer
  localparam logic [1:0]  BY_CMD         = 2'h0;
  localparam logic [1:0]  BY_AHI         = 2'h1;
  localparam logic [1:0]  BY_ALO         = 2'h2;
  localparam logic [1:0]  BY_DATA        = 2'h3;
  localparam logic [3:0]  LAST_BIT       = 4'h7;
  localparam logic [3:0]  ACK_BIT        = 4'h8;

  typedef struct packed {
    logic              vld;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } reg_wr_t;

  typedef enum {
    L_CNT, L_CNT_CAP, L_COPY, L_RUN, L_BURN, L_BURN_CNT
  } load_state_t;

endpackage

// file: rtl/clock_config_nvm_loader.sv
// configuration core: serial target, power-up load from the store, store burns
// assumes pins already synchronous to clk and serial clocks far slower than clk
//
// Behaviour
// - numerator takes effect only on update bit or at end of the power-up load
// - numerator and denominator accepted in any scaling
// - registers loaded from store before operation
// - store writable in circuit at most twice
// - old stored image unreachable after new burn
// - all control through serial register accesses
// - select pin chooses I2C or SPI target
// - SPI runs four-wire or three-wire
// - stored image starts clocks without serial access
// - output six amplitude at 0x128 bits 6:4
// - runs with every stored value including overrides
`timescale 1ns/10ps
`default_nettype none
module clock_config_nvm_loader #(
  parameter logic [6:0] I2C_ADDR = 7'h2a  // target address, arbitrary value
) (
  input  wire logic                           clk,               // 100 MHz clock
  input  wire logic                           resetn,            // async reset, active low
  input  wire logic                           i2c_sel,           // high selects I2C
  input  wire logic                           scl_sclk,          // I2C SCL or SPI SCLK
  input  wire logic                           cs_n,              // SPI chip select
  input  wire logic                           sdio_in,           // SDA / SDIO level
  input  wire logic                           sdi,               // SPI four-wire data in
  output var  logic                           sdio_out_q,        // SDA / SDIO drive value
  output var  logic                           sdio_oe_n_q,       // low while driving SDA / SDIO
  output var  logic                           sdo_out_q,         // SPI four-wire data out
  output var  logic                           sdo_oe_n_q,        // low while driving SDO
  output var  logic [8*clkcfg_pkg::NUM_BYTES-1:0] num_active_q,  // applied numerator
  output var  logic [8*clkcfg_pkg::DEN_BYTES-1:0] den_active_q,  // applied denominator
  output var  logic [clkcfg_pkg::OUT6_W-1:0]  output_six_amplitude_q, // output six amplitude
  output var  logic                           clocks_run_q       // configuration live
);

  localparam int NUM_W = 8 * clkcfg_pkg::NUM_BYTES;
  localparam int DEN_W = 8 * clkcfg_pkg::DEN_BYTES;
  localparam int AW    = clkcfg_pkg::ADDR_W;

  if (clkcfg_pkg::NREG != (1 << AW)) begin : g_chk
    $error("register space must fill the index width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  clkcfg_pkg::load_state_t      st_q;
  logic [AW:0]                  idx_q;
  logic                         cp_vld_q;
  logic [AW-1:0]                cp_addr_q;
  logic [1:0]                   used_q;
  logic                         refused_q;
  logic                         burn_req_q;
  logic                         i2c_mode_q;
  logic                         sel_done_q;
  logic                         spi_3w_q;
  logic                         scl_q;
  logic                         sda_q;
  logic                         active_q;
  logic [3:0]                   bit_q;
  logic [1:0]                   by_q;
  logic                         rd_q;
  logic                         ack_q;
  logic [7:0]                   sh_q;
  logic [7:0]                   tx_q;
  logic [AW-1:0]                haddr_q;
  logic                         stat_sel_q;
  clkcfg_pkg::reg_wr_t          host_wr_q;
  clkcfg_pkg::reg_wr_t          wr;
  logic [NUM_W-1:0]             num_stage_q;
  logic [DEN_W-1:0]             den_stage_q;
  logic                         apply_q;
  logic                         reg_we;
  logic [AW-1:0]                reg_addr;
  logic [7:0]                   reg_wd;
  logic [7:0]                   reg_rd;
  logic                         sto_we;
  logic [clkcfg_pkg::STO_AW-1:0] sto_addr;
  logic [7:0]                   sto_wd;
  logic [7:0]                   sto_rd;
  logic [7:0]                   rd_data;
  logic [7:0]                   stat;
  logic                         run;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         din;
  logic [7:0]                   rx;

  ////////////////////////////////////////////////////////////////////////////
  // memories: live registers and the non-volatile store

  cfg_mem #(.AW(AW), .DW(8), .INIT_ZERO(1'b0)) u_regs (
    .clk     (clk),
    .we      (reg_we),
    .addr    (reg_addr),
    .wdata   (reg_wd),
    .rdata_q (reg_rd)
  );

  cfg_mem #(.AW(clkcfg_pkg::STO_AW), .DW(8), .INIT_ZERO(1'b1)) u_store (
    .clk     (clk),
    .we      (sto_we),
    .addr    (sto_addr),
    .wdata   (sto_wd),
    .rdata_q (sto_rd)
  );

  assign run = (st_q == clkcfg_pkg::L_RUN);

  // host is locked out while loading or burning, so the image copied is consistent
  always_comb begin
    wr       = '0;
    reg_we   = 1'b0;
    reg_addr = haddr_q;
    reg_wd   = sto_rd;
    sto_we   = 1'b0;
    sto_wd   = reg_rd;
    sto_addr = {used_q, idx_q[AW-1:0]};
    unique case (st_q)
      clkcfg_pkg::L_CNT, clkcfg_pkg::L_CNT_CAP, clkcfg_pkg::L_BURN_CNT: begin
        sto_addr = {clkcfg_pkg::CNT_BANK, {AW{1'b0}}};
        sto_we   = (st_q == clkcfg_pkg::L_BURN_CNT);
        sto_wd   = {6'h00, used_q + 2'h1};
      end
      clkcfg_pkg::L_COPY: begin
        reg_addr = cp_addr_q;
        reg_we   = cp_vld_q;
        wr       = '{vld: cp_vld_q, addr: cp_addr_q, data: sto_rd};
      end
      clkcfg_pkg::L_BURN: begin
        reg_addr = idx_q[AW-1:0];
        sto_addr = {used_q + 2'h1, cp_addr_q};
        sto_we   = cp_vld_q;
      end
      clkcfg_pkg::L_RUN: begin
        wr       = host_wr_q;
        reg_we   = host_wr_q.vld;
        reg_wd   = host_wr_q.data;
        if (host_wr_q.vld) begin
          reg_addr = host_wr_q.addr;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // load and burn sequencer

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= clkcfg_pkg::L_CNT;
      idx_q     <= '0;
      cp_vld_q  <= 1'b0;
      cp_addr_q <= '0;
      used_q    <= 2'h0;
      refused_q <= 1'b0;
      apply_q   <= 1'b0;
    end else begin
      apply_q  <= 1'b0;
      cp_vld_q <= 1'b0;
      unique case (st_q)
        clkcfg_pkg::L_CNT: st_q <= clkcfg_pkg::L_CNT_CAP;
        clkcfg_pkg::L_CNT_CAP: begin
          // bank holding the newest image; a corrupt count falls back safely
          used_q <= (sto_rd > 8'(clkcfg_pkg::MAX_BURNS)) ? 2'(clkcfg_pkg::MAX_BURNS)
                                                          : sto_rd[1:0];
          idx_q  <= '0;
          st_q   <= clkcfg_pkg::L_COPY;
        end
        clkcfg_pkg::L_COPY: begin
          cp_vld_q  <= (idx_q < (AW+1)'(clkcfg_pkg::NREG));
          cp_addr_q <= idx_q[AW-1:0];
          idx_q     <= idx_q + 1'b1;
          if (idx_q == (AW+1)'(clkcfg_pkg::NREG + 1)) begin
            apply_q <= 1'b1;
            st_q    <= clkcfg_pkg::L_RUN;
          end
        end
        clkcfg_pkg::L_RUN: begin
          idx_q <= '0;
          if (burn_req_q) begin
            if (used_q == 2'(clkcfg_pkg::MAX_BURNS)) begin
              refused_q <= 1'b1;
            end else begin
              refused_q <= 1'b0;
              st_q      <= clkcfg_pkg::L_BURN;
            end
          end
        end
        clkcfg_pkg::L_BURN: begin
          cp_vld_q  <= (idx_q < (AW+1)'(clkcfg_pkg::NREG));
          cp_addr_q <= idx_q[AW-1:0];
          idx_q     <= idx_q + 1'b1;
          if (idx_q == (AW+1)'(clkcfg_pkg::NREG + 1)) begin
            st_q <= clkcfg_pkg::L_BURN_CNT;
          end
        end
        clkcfg_pkg::L_BURN_CNT: begin
          used_q <= used_q + 2'h1;
          st_q   <= clkcfg_pkg::L_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadowed fields, fed by every register write whether host or loader

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      num_stage_q            <= '0;
      den_stage_q            <= '0;
      num_active_q           <= '0;
      den_active_q           <= '0;
      output_six_amplitude_q <= '0;
      spi_3w_q               <= 1'b0;
      burn_req_q             <= 1'b0;
      clocks_run_q           <= 1'b0;
    end else begin
      burn_req_q <= wr.vld && run && (wr.addr == clkcfg_pkg::STO_CMD_ADDR)
                    && (wr.data == clkcfg_pkg::STO_CMD_GO);
      if (apply_q) begin
        clocks_run_q <= 1'b1;
      end
      if (wr.vld) begin
        // any power-of-two scaling is just a byte pattern here; ratio is kept as written
        for (int b = 0; b < clkcfg_pkg::NUM_BYTES; b++) begin
          if (wr.addr == clkcfg_pkg::NUM_BASE + AW'(b)) begin
            num_stage_q[8*b +: 8] <= wr.data;
          end
        end
        for (int b = 0; b < clkcfg_pkg::DEN_BYTES; b++) begin
          if (wr.addr == clkcfg_pkg::DEN_BASE + AW'(b)) begin
            den_stage_q[8*b +: 8] <= wr.data;
          end
        end
        if (wr.addr == clkcfg_pkg::AMP6_ADDR) begin
          output_six_amplitude_q <= wr.data[clkcfg_pkg::OUT6_LSB +: clkcfg_pkg::OUT6_W];
        end
        if (wr.addr == clkcfg_pkg::SPI_CFG_ADDR) begin
          spi_3w_q <= wr.data[clkcfg_pkg::SPI_3W_BIT];
        end
      end
      // both terms change on one edge, so the divider never sees a half-written ratio
      if (apply_q || (wr.vld && run && (wr.addr == clkcfg_pkg::UPDATE_ADDR)
                      && wr.data[clkcfg_pkg::UPDATE_BIT])) begin
        num_active_q <= num_stage_q;
        den_active_q <= den_stage_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial target, I2C or SPI

  assign stat     = {4'h0, refused_q, ~run, used_q};
  assign rd_data  = stat_sel_q ? stat : reg_rd;
  assign scl_rise = scl_sclk & ~scl_q;
  assign scl_fall = ~scl_sclk & scl_q;
  assign din      = (i2c_mode_q || spi_3w_q) ? sdio_in : sdi;
  assign rx       = {sh_q[6:0], din};

  // interface choice is caught once after reset so a moving pin cannot flip it mid-transfer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_done_q <= 1'b0;
      i2c_mode_q <= 1'b0;
    end else if (!sel_done_q) begin
      sel_done_q <= 1'b1;
      i2c_mode_q <= i2c_sel;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q       <= 1'b0;
      sda_q       <= 1'b1;
      active_q    <= 1'b0;
      bit_q       <= '0;
      by_q        <= clkcfg_pkg::BY_CMD;
      rd_q        <= 1'b0;
      ack_q       <= 1'b0;
      sh_q        <= '0;
      tx_q        <= '0;
      haddr_q     <= '0;
      stat_sel_q  <= 1'b0;
      host_wr_q   <= '0;
      sdio_out_q  <= 1'b1;
      sdio_oe_n_q <= 1'b1;
      sdo_out_q   <= 1'b0;
      sdo_oe_n_q  <= 1'b1;
    end else begin
      scl_q      <= scl_sclk;
      sda_q      <= sdio_in;
      host_wr_q  <= '0;
      stat_sel_q <= (haddr_q == clkcfg_pkg::STO_STAT_ADDR);
      if (i2c_mode_q ? (scl_sclk && sda_q && !sdio_in) : cs_n) begin
        // start condition, or SPI deselect: frame restarts
        active_q    <= i2c_mode_q;
        bit_q       <= '0;
        by_q        <= clkcfg_pkg::BY_CMD;
        rd_q        <= 1'b0;
        sdio_oe_n_q <= 1'b1;
        sdo_oe_n_q  <= 1'b1;
      end else if (i2c_mode_q && scl_sclk && !sda_q && sdio_in) begin
        active_q    <= 1'b0;                               // stop condition
        sdio_oe_n_q <= 1'b1;
      end else if ((active_q || !i2c_mode_q) && scl_rise) begin
        if (bit_q == clkcfg_pkg::ACK_BIT) begin
          bit_q <= '0;
          if (rd_q && sdio_in) begin
            active_q <= 1'b0;                              // master declined more data
          end
        end else begin
          sh_q  <= rx;
          bit_q <= (bit_q == clkcfg_pkg::LAST_BIT && !i2c_mode_q) ? 4'h0 : bit_q + 4'h1;
          ack_q <= 1'b0;
          if (bit_q == clkcfg_pkg::LAST_BIT && !(rd_q && by_q == clkcfg_pkg::BY_DATA)) begin
            ack_q <= 1'b1;
            unique case (by_q)
              clkcfg_pkg::BY_CMD: begin
                if (i2c_mode_q) begin
                  ack_q    <= (rx[7:1] == I2C_ADDR);
                  active_q <= (rx[7:1] == I2C_ADDR);
                  rd_q     <= rx[0];
                  by_q     <= rx[0] ? clkcfg_pkg::BY_DATA : clkcfg_pkg::BY_AHI;
                end else begin
                  rd_q <= (rx == clkcfg_pkg::SPI_CMD_RD);
                  by_q <= clkcfg_pkg::BY_AHI;
                end
              end
              clkcfg_pkg::BY_AHI: begin
                haddr_q[AW-1:8] <= rx[AW-9:0];
                by_q            <= clkcfg_pkg::BY_ALO;
              end
              clkcfg_pkg::BY_ALO: begin
                haddr_q[7:0] <= rx;
                by_q         <= clkcfg_pkg::BY_DATA;
              end
              clkcfg_pkg::BY_DATA: begin
                // writes during load or burn are dropped, addressing still advances
                host_wr_q <= '{vld: run, addr: haddr_q, data: rx};
                haddr_q   <= haddr_q + 1'b1;
              end
            endcase
          end
        end
      end else if ((active_q || !i2c_mode_q) && scl_fall) begin
        if (i2c_mode_q) begin
          sdio_out_q  <= 1'b0;
          sdio_oe_n_q <= 1'b1;
          if (bit_q == clkcfg_pkg::ACK_BIT && ack_q) begin
            sdio_oe_n_q <= 1'b0;
          end else if (rd_q && by_q == clkcfg_pkg::BY_DATA && bit_q < clkcfg_pkg::ACK_BIT) begin
            // open drain: a one is sent by releasing the line
            tx_q        <= (bit_q == 4'h0) ? {rd_data[6:0], 1'b0} : {tx_q[6:0], 1'b0};
            sdio_oe_n_q <= (bit_q == 4'h0) ? rd_data[7] : tx_q[7];
            if (bit_q == 4'h0) begin
              haddr_q <= haddr_q + 1'b1;
            end
          end
        end else if (rd_q && by_q == clkcfg_pkg::BY_DATA) begin
          tx_q        <= (bit_q == 4'h0) ? {rd_data[6:0], 1'b0} : {tx_q[6:0], 1'b0};
          sdio_out_q  <= (bit_q == 4'h0) ? rd_data[7] : tx_q[7];
          sdo_out_q   <= (bit_q == 4'h0) ? rd_data[7] : tx_q[7];
          sdio_oe_n_q <= ~spi_3w_q;
          sdo_oe_n_q  <= spi_3w_q;
          if (bit_q == 4'h0) begin
            haddr_q <= haddr_q + 1'b1;
          end
        end
      end
    end
  end

endmodule // clock_config_nvm_loader
`default_nettype wire

// file: tb/clock_config_nvm_loader_properties.sv
// port checker for the configuration core
// assumes i2c_sel only moves while resetn is low
`timescale 1ns/10ps
`default_nettype none
module clock_config_nvm_loader_properties (
  input wire logic        clk,                    // clock
  input wire logic        resetn,                 // reset, active low
  input wire logic        i2c_sel,                // bus select
  input wire logic        scl_sclk,               // serial clock
  input wire logic        cs_n,                   // spi select
  input wire logic        sdio_in,                // sdio level
  input wire logic        sdi,                    // spi data in
  input wire logic        sdio_out_q,             // sdio drive
  input wire logic        sdio_oe_n_q,            // sdio enable
  input wire logic        sdo_out_q,              // sdo drive
  input wire logic        sdo_oe_n_q,             // sdo enable
  input wire logic [47:0] num_active_q,           // numerator
  input wire logic [31:0] den_active_q,           // denominator
  input wire logic [2:0]  output_six_amplitude_q, // amplitude
  input wire logic        clocks_run_q            // running
);
  logic       sclk_q;
  logic [4:0] rise_q;
  logic [4:0] fall_q;
  logic [2:0] run_q;
  logic [9:0] load_q;
  // counters saturate so a long idle never wraps into a false quiet
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      rise_q <= '1;
      fall_q <= '1;
      run_q  <= '0;
      load_q <= '0;
    end else begin
      sclk_q <= scl_sclk;
      rise_q <= (scl_sclk && !sclk_q) ? 5'h00 : rise_q + 5'((rise_q != 5'h1f));
      fall_q <= (!scl_sclk && sclk_q) ? 5'h00 : fall_q + 5'((fall_q != 5'h1f));
      run_q  <= !clocks_run_q ? 3'h0 : run_q + 3'((run_q != 3'h7));
      load_q <= load_q + 10'((!clocks_run_q && load_q != 10'h3ff));
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RESET_CLEAN: assert property (
      $rose(resetn) |-> sdio_oe_n_q && sdo_oe_n_q && !clocks_run_q && num_active_q == '0)
    else $error("outputs not clean after reset");
  AST_RUN_STAYS: assert property (clocks_run_q |=> clocks_run_q)
    else $error("run flag dropped");
  AST_RUN_BOUND: assert property (load_q < 10'h320)
    else $error("load never finished");
  AST_RUN_NOT_EARLY: assert property ($rose(clocks_run_q) |-> load_q >= 10'h1fe)
    else $error("run before whole image loaded");
  AST_NUM_CAUSE: assert property (
      $changed(num_active_q) || $changed(den_active_q) |-> rise_q < 5'h0e || run_q < 3'h4)
    else $error("divider changed without update");
  AST_AMP_CAUSE: assert property (
      $changed(output_six_amplitude_q) |-> rise_q < 5'h0e || run_q < 3'h4)
    else $error("amplitude changed without access");
  AST_SDO_RELEASE: assert property (cs_n [*4] |-> sdo_oe_n_q)
    else $error("sdo driven while deselected");
  AST_SDIO_RELEASE: assert property ((!i2c_sel && cs_n) [*4] |-> sdio_oe_n_q)
    else $error("sdio driven while deselected");
  AST_SDO_STEADY: assert property (!sdo_oe_n_q && $changed(sdo_out_q) |-> fall_q < 5'h08)
    else $error("sdo moved away from sclk fall");
  AST_OPEN_DRAIN: assert property (i2c_sel && !sdio_oe_n_q |-> !sdio_out_q)
    else $error("sda driven high");
  cover property ($rose(clocks_run_q));
  cover property ($fell(sdo_oe_n_q));
  cover property (i2c_sel && $fell(sdio_oe_n_q));
  cover property ($changed(num_active_q));
endmodule // clock_config_nvm_loader_properties
bind clock_config_nvm_loader clock_config_nvm_loader_properties u_clock_config_nvm_loader_properties (
  .clk(clk), .resetn(resetn), .i2c_sel(i2c_sel), .scl_sclk(scl_sclk), .cs_n(cs_n),
  .sdio_in(sdio_in), .sdi(sdi), .sdio_out_q(sdio_out_q), .sdio_oe_n_q(sdio_oe_n_q),
  .sdo_out_q(sdo_out_q), .sdo_oe_n_q(sdo_oe_n_q), .num_active_q(num_active_q),
  .den_active_q(den_active_q), .output_six_amplitude_q(output_six_amplitude_q),
  .clocks_run_q(clocks_run_q));
`default_nettype wire

// file: tb/host_model.sv
// host controller model: spi mode 0 and i2c write frames
// assumes the bench resolves sdio and sdo and feeds them back
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic clk,      // system clock
  input  wire logic line,     // resolved sdio level
  input  wire logic sdo_line, // resolved sdo level
  output var  logic scl_sclk, // serial clock
  output var  logic cs_n,     // spi select
  output var  logic sdi,      // spi data in
  output var  logic host_oe,  // host drives sdio
  output var  logic host_val  // host sdio value
);
  initial begin
    scl_sclk = 1'b0;
    cs_n     = 1'b1;
    sdi      = 1'b0;
    host_oe  = 1'b0;
    host_val = 1'b1;
  end
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // data moves with the fall, both wires carry it so either spi form works
  task automatic sbyte(input logic [7:0] b, input logic drv, input logic tw, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      scl_sclk <= 1'b0;
      sdi      <= b[i];
      host_val <= b[i];
      host_oe  <= drv;
      half();
      r[i] = tw ? line : sdo_line;
      scl_sclk <= 1'b1;
      half();
    end
  endtask
  task automatic spi(input logic rd, input logic [8:0] a, input logic [7:0] d, input logic tw,
                     output logic [7:0] q);
    logic [7:0] r;
    @(posedge clk);
    cs_n <= 1'b0;
    sbyte(rd ? clkcfg_pkg::SPI_CMD_RD : 8'h00, 1'b1, tw, r);
    sbyte({7'h00, a[8]}, 1'b1, tw, r);
    sbyte(a[7:0], 1'b1, tw, r);
    sbyte(d, !rd, tw, q);
    scl_sclk <= 1'b0;
    host_oe  <= 1'b0;
    half();
    cs_n <= 1'b1;
    half();
  endtask
  // sda only moves mid low phase so no false start or stop is seen
  task automatic ibit(input logic b, output logic r);
    repeat (4) @(posedge clk);
    host_val <= b;
    repeat (4) @(posedge clk);
    scl_sclk <= 1'b1;
    half();
    r = line;
    scl_sclk <= 1'b0;
  endtask
  task automatic i2c_wr(input logic [7:0] b0, input logic [8:0] a, input logic [7:0] d,
                        output logic [3:0] acks);
    logic [31:0] w;
    logic        r;
    w = {b0, 7'h00, a[8], a[7:0], d};
    @(posedge clk);
    host_oe  <= 1'b1;
    scl_sclk <= 1'b1;
    half();
    host_val <= 1'b0;
    half();
    scl_sclk <= 1'b0;
    for (int j = 31; j >= 0; j--) begin
      ibit(w[j], r);
      if (j % 8 == 0) begin
        ibit(1'b1, r);
        acks = {acks[2:0], r};
      end
    end
    repeat (4) @(posedge clk);
    host_val <= 1'b0;
    repeat (4) @(posedge clk);
    scl_sclk <= 1'b1;
    half();
    host_val <= 1'b1;
    half();
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/tb_clock_config_nvm_loader.sv
// self-checking bench for the configuration core over spi and i2c
// assumes host_model drives the serial pins; sdio has a pull-up
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_clock_config_nvm_loader;
  localparam logic [47:0] NUM_V = 48'h80f0_0c30_0a01;
  localparam logic [31:0] DEN_V = 32'h4000_0c01;
  localparam logic [6:0]  I2C_A = 7'h2a; // arbitrary target address
  logic        clk, resetn, i2c_sel, tog, scl_sclk, cs_n, sdi, host_oe, host_val;
  logic        sdio_out_q, sdio_oe_n_q, sdo_out_q, sdo_oe_n_q, clocks_run_q;
  logic [47:0] num_active_q;
  logic [31:0] den_active_q;
  logic [2:0]  output_six_amplitude_q;
  logic [7:0]  q;
  logic [3:0]  acks;
  int          miscompares = 0;
  int          tests_run = 0;
  // released sdo toggles so a stale bit cannot pass for data
  wire logic   host_term = host_oe ? host_val : 1'b1;
  wire logic   sdio_line = sdio_oe_n_q ? host_term : (sdio_out_q & host_term);
  wire logic   sdo_line  = sdo_oe_n_q ? tog : sdo_out_q;
  clock_config_nvm_loader #(.I2C_ADDR(I2C_A)) u_clock_config_nvm_loader (
    .clk(clk), .resetn(resetn), .i2c_sel(i2c_sel), .scl_sclk(scl_sclk), .cs_n(cs_n),
    .sdio_in(sdio_line), .sdi(sdi), .sdio_out_q(sdio_out_q), .sdio_oe_n_q(sdio_oe_n_q),
    .sdo_out_q(sdo_out_q), .sdo_oe_n_q(sdo_oe_n_q), .num_active_q(num_active_q),
    .den_active_q(den_active_q), .output_six_amplitude_q(output_six_amplitude_q),
    .clocks_run_q(clocks_run_q));
  host_model u_host_model (
    .clk(clk), .line(sdio_line), .sdo_line(sdo_line), .scl_sclk(scl_sclk), .cs_n(cs_n),
    .sdi(sdi), .host_oe(host_oe), .host_val(host_val));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tog <= ~tog;
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    u_host_model.spi(1'b0, a, d, 1'b0, q);
  endtask
  task automatic rd(input logic [8:0] a, input logic tw);
    u_host_model.spi(1'b1, a, 8'h00, tw, q);
  endtask
  task automatic do_reset(input logic sel);
    resetn  <= 1'b0;
    i2c_sel <= sel;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 2000 && clocks_run_q !== 1'b1; i++) @(posedge clk);
    `CHK(clocks_run_q, 1'b1)
  endtask
  task automatic burn(input logic [3:0] st);
    wr(clkcfg_pkg::STO_CMD_ADDR, clkcfg_pkg::STO_CMD_GO);
    q = 8'h04;
    for (int i = 0; i < 4 && q[2] !== 1'b0; i++) rd(clkcfg_pkg::STO_STAT_ADDR, 1'b0);
    `CHK(q[3:0], st)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    resetn  = 1'b0;
    i2c_sel = 1'b0;
    tog     = 1'b0;
    do_reset(1'b0);
    `CHK(num_active_q, 48'h0)
    wr(clkcfg_pkg::AMP6_ADDR, 8'h50);
    `CHK(output_six_amplitude_q, 3'h5)
    rd(clkcfg_pkg::AMP6_ADDR, 1'b0);
    `CHK(q, 8'h50)
    for (int i = 0; i < 6; i++) wr(clkcfg_pkg::NUM_BASE + 9'(i), NUM_V[8*i +: 8]);
    for (int i = 0; i < 4; i++) wr(clkcfg_pkg::DEN_BASE + 9'(i), DEN_V[8*i +: 8]);
    `CHK(num_active_q, 48'h0)
    wr(clkcfg_pkg::UPDATE_ADDR, 8'h01);
    `CHK(num_active_q, NUM_V)
    `CHK(den_active_q, DEN_V)
    wr(clkcfg_pkg::SPI_CFG_ADDR, 8'h08);
    rd(clkcfg_pkg::AMP6_ADDR, 1'b1);
    `CHK(q, 8'h50)
    wr(clkcfg_pkg::SPI_CFG_ADDR, 8'h00);
    burn(4'h1);
    wr(clkcfg_pkg::AMP6_ADDR, 8'h30);
    burn(4'h2);
    wr(clkcfg_pkg::AMP6_ADDR, 8'h70);
    burn(4'ha);
    do_reset(1'b0);
    `CHK(output_six_amplitude_q, 3'h3)
    `CHK(num_active_q, NUM_V)
    do_reset(1'b1);
    u_host_model.i2c_wr({I2C_A, 1'b0}, clkcfg_pkg::AMP6_ADDR, 8'h50, acks);
    `CHK(acks, 4'h0)
    `CHK(output_six_amplitude_q, 3'h5)
    conclude();
  end
endmodule // tb_clock_config_nvm_loader
`default_nettype wire
